// [hdl/pevr_params.svh]
// offsets, field positions and reset values of the port event router
`ifndef PEVR_PARAMS_SVH
`define PEVR_PARAMS_SVH

`define PEVR_CTL_OFFSET      12'hae8
`define PEVR_STS_OFFSET      12'haec
`define PEVR_IRQ_STS_OFFSET  12'haf0
`define PEVR_IRQ_MASK_OFFSET 12'haf4
`define PEVR_GPIO_SEL_OFFSET 12'haf8
`define PEVR_ENABLE_MSB      15
`define PEVR_ENABLE_LSB      0
`define PEVR_POLARITY_BIT    31
`define PEVR_CTL_RESET       32'h0000_0000
`define PEVR_STS_RESET       32'h0000_0000
`define PEVR_MASK_RESET      32'h0000_0000
`define PEVR_GPIO_SEL_RESET  32'h0000_0000

`endif

// [hdl/pevr_pkg.sv]
// types shared by the port event router
package pevr_pkg;
    typedef enum logic [1:0] {
        PEVR_APB_IDLE,
        PEVR_APB_ACCESS
    } pevr_apb_state_t;

    typedef logic [31:0] pevr_word_t;
endpackage : pevr_pkg

// [hdl/pevr_pin_cell.sv]
// one gpio pin cell: alternate function mux with polarity
`timescale 1ns/10ps
module pevr_pin_cell (
    input  wire logic pclk,          // system clock
    input  wire logic presetn,       // async reset, active low
    input  wire logic alt_sel,       // pin carries the event function
    input  wire logic event_active,  // routed event, true high
    input  wire logic invert,        // 1: event pin active high
    input  wire logic gpio_out,      // normal gpio output value
    input  wire logic gpio_oe,       // normal gpio output enable
    output logic      pin_out,       // pin output level
    output logic      pin_oe         // pin output enable
);
    // registered mux; idle level of the event pin follows polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else if (alt_sel) begin
            pin_out <= invert ? event_active : ~event_active;
            pin_oe  <= 1'b1;
        end else begin
            pin_out <= gpio_out;
            pin_oe  <= gpio_oe;
        end
    end
endmodule : pevr_pin_cell

// [hdl/pevr_router.sv]
// port event router: apb registers, notification suppression, event pins
// Summary of operation
// - control low sixteen bits enable per port; set bit suppresses intx, msi, pme
// - enabled port reports its suppressed notifications on its event output
// - each event output is an alternate function of a gpio pin
// - control bit 31 sets polarity: 0 active low, 1 active high
// - status reads one bit per port, set while port asserts its event
// - status bit can stay set one cycle after that port's enable bit is cleared, never longer
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "pevr_params.svh"
module pevr_router
    import pevr_pkg::*;
#(
    parameter int NPORTS = 16
) (
    input  wire logic              pclk,          // system clock
    input  wire logic              presetn,       // async reset, active low
    input  wire logic              psel,          // apb select
    input  wire logic              penable,       // apb access phase
    input  wire logic              pwrite,        // apb write
    input  wire logic [11:0]       paddr,         // apb byte address
    input  wire logic [31:0]       pwdata,        // apb write data
    output logic      [31:0]       prdata,        // apb read data
    output logic                   pready,        // apb ready
    output logic                   pslverr,       // apb error, unmapped
    input  wire logic [NPORTS-1:0] port_hp_intx,  // hot-plug intx request per port
    input  wire logic [NPORTS-1:0] port_msi,      // msi request per port
    input  wire logic [NPORTS-1:0] port_pme,      // pme request per port
    output logic      [NPORTS-1:0] out_hp_intx,   // intx passed to pcie side
    output logic      [NPORTS-1:0] out_msi,       // msi passed to pcie side
    output logic      [NPORTS-1:0] out_pme,       // pme passed to pcie side
    input  wire logic [NPORTS-1:0] gpio_out,      // gpio output value
    input  wire logic [NPORTS-1:0] gpio_oe,       // gpio output enable
    output logic      [NPORTS-1:0] port_event_pin,    // pin output level
    output logic      [NPORTS-1:0] port_event_pin_oe, // pin output enable
    output logic                   irq            // level interrupt
);
    pevr_apb_state_t   apb_state_r;
    logic [NPORTS-1:0] port_event_route_enable_r;
    logic              event_pin_polarity_invert_r;
    logic [NPORTS-1:0] port_event_active_flags_r;
    logic [NPORTS-1:0] gpio_alt_sel_r;
    logic [NPORTS-1:0] irq_sts_r;
    logic [NPORTS-1:0] irq_mask_r;
    logic [NPORTS-1:0] port_event_nxt;
    logic [NPORTS-1:0] rise_nxt;
    logic              wr_acc;
    logic              rd_acc;
    logic              setup_ph;

    // address hit test, used by read mux, write strobes and error
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `PEVR_CTL_OFFSET) | hit(a, `PEVR_STS_OFFSET)
               | hit(a, `PEVR_IRQ_STS_OFFSET) | hit(a, `PEVR_IRQ_MASK_OFFSET)
               | hit(a, `PEVR_GPIO_SEL_OFFSET);
    endfunction : mapped

    // apb slave: one setup cycle, then one access cycle with pready high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state_r <= PEVR_APB_IDLE;
        end else begin
            unique case (apb_state_r)
                PEVR_APB_IDLE: begin
                    if (psel && !penable) begin
                        apb_state_r <= PEVR_APB_ACCESS;
                    end
                end
                PEVR_APB_ACCESS: begin
                    apb_state_r <= PEVR_APB_IDLE;
                end
                default: begin
                    apb_state_r <= PEVR_APB_IDLE;
                end
            endcase
        end
    end

    // access strobes; pready is registered so the access phase lasts one cycle
    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && penable && !pwrite && pready;
    // setup counts only while idle, so one request never earns a second pready
    assign setup_ph = psel && !penable && (apb_state_r == PEVR_APB_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_ph;
        end
    end

    // error answer for unmapped addresses, driven with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_ph && !mapped(paddr);
        end
    end

    // read data registered in setup cycle, valid throughout access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, `PEVR_CTL_OFFSET)) begin
                prdata[`PEVR_ENABLE_MSB:`PEVR_ENABLE_LSB] <= port_event_route_enable_r;
                prdata[`PEVR_POLARITY_BIT] <= event_pin_polarity_invert_r;
            end else if (hit(paddr, `PEVR_STS_OFFSET)) begin
                prdata[NPORTS-1:0] <= port_event_active_flags_r;
            end else if (hit(paddr, `PEVR_IRQ_STS_OFFSET)) begin
                prdata[NPORTS-1:0] <= irq_sts_r;
            end else if (hit(paddr, `PEVR_IRQ_MASK_OFFSET)) begin
                prdata[NPORTS-1:0] <= irq_mask_r;
            end else if (hit(paddr, `PEVR_GPIO_SEL_OFFSET)) begin
                prdata[NPORTS-1:0] <= gpio_alt_sel_r;
            end
        end
    end

    // control register; only enable field and polarity bit stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_event_route_enable_r   <= NPORTS'(`PEVR_CTL_RESET);
            event_pin_polarity_invert_r <= 1'b0;
        end else if (wr_acc && hit(paddr, `PEVR_CTL_OFFSET)) begin
            port_event_route_enable_r   <= pwdata[NPORTS-1:0];
            event_pin_polarity_invert_r <= pwdata[`PEVR_POLARITY_BIT];
        end
    end

    // gpio alternate function select and interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_alt_sel_r <= NPORTS'(`PEVR_GPIO_SEL_RESET);
            irq_mask_r     <= NPORTS'(`PEVR_MASK_RESET);
        end else if (wr_acc) begin
            if (hit(paddr, `PEVR_GPIO_SEL_OFFSET)) begin
                gpio_alt_sel_r <= pwdata[NPORTS-1:0];
            end
            if (hit(paddr, `PEVR_IRQ_MASK_OFFSET)) begin
                irq_mask_r <= pwdata[NPORTS-1:0];
            end
        end
    end

    // an enabled port's notifications become its event; disabled gives none
    assign port_event_nxt = port_event_route_enable_r
                          & (port_hp_intx | port_msi | port_pme);
    assign rise_nxt = port_event_nxt & ~port_event_active_flags_r;

    // status flags track the event level; writes never reach them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_event_active_flags_r <= NPORTS'(`PEVR_STS_RESET);
        end else begin
            port_event_active_flags_r <= port_event_nxt;
        end
    end

    // suppression: enabled ports pass no notification to the pcie side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_hp_intx <= '0;
            out_msi     <= '0;
            out_pme     <= '0;
        end else begin
            out_hp_intx <= port_hp_intx & ~port_event_route_enable_r;
            out_msi     <= port_msi & ~port_event_route_enable_r;
            out_pme     <= port_pme & ~port_event_route_enable_r;
        end
    end

    // sticky interrupt status on event rise; set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_r <= '0;
        end else if (wr_acc && hit(paddr, `PEVR_IRQ_STS_OFFSET)) begin
            irq_sts_r <= (irq_sts_r & ~pwdata[NPORTS-1:0]) | rise_nxt;
        end else begin
            irq_sts_r <= irq_sts_r | rise_nxt;
        end
    end

    // interrupt output registered, so it lags status by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_sts_r & irq_mask_r);
        end
    end

    // one pin cell per port; event drives the pin only when selected
    for (genvar i = 0; i < NPORTS; i++) begin : g_pin
        pevr_pin_cell u_cell (
            .pclk         (pclk),
            .presetn      (presetn),
            .alt_sel      (gpio_alt_sel_r[i]),
            .event_active (port_event_active_flags_r[i]),
            .invert       (event_pin_polarity_invert_r),
            .gpio_out     (gpio_out[i]),
            .gpio_oe      (gpio_oe[i]),
            .pin_out      (port_event_pin[i]),
            .pin_oe       (port_event_pin_oe[i])
        );
    end
endmodule : pevr_router

// [tb/pevr_router_assertions.sv]
// concurrent checks on the port event router ports
`timescale 1ns/10ps
`include "pevr_params.svh"
module pevr_router_chk #(
    parameter int NPORTS = 16
) (
    input wire logic              pclk,             // clock
    input wire logic              presetn,          // reset, low
    input wire logic              psel,             // select
    input wire logic              penable,          // access
    input wire logic              pwrite,           // write
    input wire logic [11:0]       paddr,            // address
    input wire logic [31:0]       prdata,           // read data
    input wire logic              pready,           // ready
    input wire logic              pslverr,          // error
    input wire logic [NPORTS-1:0] port_hp_intx,     // intx in
    input wire logic [NPORTS-1:0] port_msi,         // msi in
    input wire logic [NPORTS-1:0] port_pme,         // pme in
    input wire logic [NPORTS-1:0] out_hp_intx,      // intx out
    input wire logic [NPORTS-1:0] out_msi,          // msi out
    input wire logic [NPORTS-1:0] out_pme,          // pme out
    input wire logic [NPORTS-1:0] gpio_oe,          // gpio enable
    input wire logic [NPORTS-1:0] port_event_pin_oe // pin enable
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic [NPORTS-1:0] req_any = port_hp_intx | port_msi | port_pme;
    wire logic              rd_ack  = psel && penable && pready && !pwrite;
    // suppression may drop a notification but never invent one
    property p_msi_kept; (out_msi & ~$past(port_msi)) == '0; endproperty
    a_msi_kept: assert property (p_msi_kept) else $error("msi out without request");
    property p_hp_kept;
        ((out_hp_intx & ~$past(port_hp_intx)) | (out_pme & ~$past(port_pme))) == '0;
    endproperty
    a_hp_kept: assert property (p_hp_kept) else $error("intx or pme out without request");
    property p_err_ack; pslverr |-> psel && penable && pready; endproperty
    a_err_ack: assert property (p_err_ack) else $error("error outside access");
    property p_ctl_rsv; rd_ack && paddr == `PEVR_CTL_OFFSET |-> prdata[30:16] == '0; endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved bits set");
    property p_sts_rsv; rd_ack && paddr == `PEVR_STS_OFFSET |-> prdata[31:16] == '0; endproperty
    a_sts_rsv: assert property (p_sts_rsv) else $error("status reserved bits set");
    // a status bit needs a request on that port shortly before
    property p_sts_cause; rd_ack && paddr == `PEVR_STS_OFFSET |-> (prdata[15:0] &
        ~($past(req_any) | $past(req_any, 2) | $past(req_any, 3))) == '0; endproperty
    a_sts_cause: assert property (p_sts_cause) else $error("status without event");
    // an undriven pin must be one the gpio left undriven too
    property p_oe_gpio; $past(presetn) |-> (~port_event_pin_oe & $past(gpio_oe)) == '0; endproperty
    a_oe_gpio: assert property (p_oe_gpio) else $error("pin enable lost");
endmodule : pevr_router_chk

// [tb/pevr_pin_monitor.sv]
// far-side logic watching the event pins
`timescale 1ns/10ps
module pevr_pin_monitor #(
    parameter int NPORTS = 16
) (
    input  wire logic              pclk,     // clock
    input  wire logic [NPORTS-1:0] pin,      // pin level
    input  wire logic [NPORTS-1:0] pin_oe,   // pin driven
    input  wire logic              act_high, // expected polarity
    output logic      [NPORTS-1:0] seen      // events seen
);
    // board pull-up lifts a pin nobody drives
    wire logic [NPORTS-1:0] lvl = (pin_oe & pin) | ~pin_oe;
    always_ff @(posedge pclk) begin
        seen <= pin_oe & (act_high ? lvl : ~lvl);
    end
endmodule : pevr_pin_monitor

// [tb/test_port_event_pin_router.sv]
// self-checking bench of the port event router
`timescale 1ns/10ps
`include "pevr_params.svh"
module test_port_event_pin_router;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, act_high;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] intx, msi, pme, o_intx, o_msi, o_pme, g_out, g_oe, pin, pin_oe, seen, lf;
    logic [32:0] expq[$];
    int          err_total, checks, cyc;
    pevr_router u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port_hp_intx(intx), .port_msi(msi), .port_pme(pme),
        .out_hp_intx(o_intx), .out_msi(o_msi), .out_pme(o_pme), .gpio_out(g_out),
        .gpio_oe(g_oe), .port_event_pin(pin), .port_event_pin_oe(pin_oe), .irq);
    pevr_pin_monitor u_far (.pclk, .pin, .pin_oe, .act_high, .seen);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    function automatic logic [15:0] nxt();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : nxt
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // one apb transfer; its expected {error, data} goes to the queue expq
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [32:0] e);
        @(posedge pclk);
        expq.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // hold the request until pready is seen high at a rising edge
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // random notifications held steady, then outputs, pins and status
    task automatic evt(input logic [15:0] en, input logic pol);
        logic [15:0] ev;
        @(posedge pclk);
        intx <= nxt();
        msi <= nxt();
        pme <= nxt() & nxt();
        g_out <= nxt();
        g_oe <= nxt();
        act_high <= pol;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        ev = en & (intx | msi | pme);
        chk(o_intx, intx & ~en);
        chk(o_msi, msi & ~en);
        chk(o_pme, pme & ~en);
        chk(pin, {17'h0, pol ? ev : ~ev});
        chk(seen, ev);
        xfer(1'b0, `PEVR_STS_OFFSET, 32'h0, ev);
    endtask : evt
    task automatic irqchk(input logic e);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(irq, e);
    endtask : irqchk
    // completed transfers compared at the edge that ends them, against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready)
            chk({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, act_high} = '0;
        {paddr, pwdata, intx, msi, pme, g_out, g_oe} = '0;
        lf = 16'd6503;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, `PEVR_CTL_OFFSET, 32'h0, 33'h0);
        xfer(1'b0, `PEVR_STS_OFFSET, 32'h0, 33'h0);
        xfer(1'b1, 12'ha00, 32'hffff_ffff, 33'h1_0000_0000);
        xfer(1'b0, 12'ha00, 32'h0, 33'h1_0000_0000);
        xfer(1'b1, `PEVR_GPIO_SEL_OFFSET, 32'h0000_ffff, 33'h0);
        xfer(1'b0, `PEVR_GPIO_SEL_OFFSET, 32'h0, 33'h0_0000_ffff);
        xfer(1'b1, `PEVR_CTL_OFFSET, 32'hffff_0f3c, 33'h0);
        xfer(1'b0, `PEVR_CTL_OFFSET, 32'h0, 33'h0_8000_0f3c);
        xfer(1'b1, `PEVR_STS_OFFSET, 32'hffff_ffff, 33'h0);
        repeat (6) evt(16'h0f3c, 1'b1);
        xfer(1'b1, `PEVR_CTL_OFFSET, 32'h0000_c0a1, 33'h0);
        repeat (6) evt(16'hc0a1, 1'b0);
        // quiet ports, clear sticky events, then a fresh rise on port 0
        @(posedge pclk);
        {intx, msi, pme} <= '0;
        xfer(1'b1, `PEVR_IRQ_MASK_OFFSET, 32'h0000_ffff, 33'h0);
        xfer(1'b1, `PEVR_IRQ_STS_OFFSET, 32'h0000_ffff, 33'h0);
        irqchk(1'b0);
        @(posedge pclk);
        msi <= 16'h0001;
        irqchk(1'b1);
        xfer(1'b1, `PEVR_IRQ_MASK_OFFSET, 32'h0, 33'h0);
        irqchk(1'b0);
        xfer(1'b1, `PEVR_IRQ_STS_OFFSET, 32'h0000_0001, 33'h0);
        xfer(1'b1, `PEVR_IRQ_MASK_OFFSET, 32'h0000_ffff, 33'h0);
        irqchk(1'b0);
        // alternate function off: gpio enable reaches the pins again
        xfer(1'b0, `PEVR_IRQ_MASK_OFFSET, 32'h0, 33'h0_0000_ffff);
        xfer(1'b1, `PEVR_GPIO_SEL_OFFSET, 32'h0, 33'h0);
        irqchk(1'b0);
        chk(pin_oe, g_oe);
        chk(pin, g_out);
        chk(expq.size(), 33'h0);
        conclude();
    end
endmodule : test_port_event_pin_router
bind pevr_router pevr_router_chk #(.NPORTS(NPORTS)) u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .port_hp_intx, .port_msi, .port_pme,
    .out_hp_intx, .out_msi, .out_pme, .gpio_oe, .port_event_pin_oe);
